// ### bench/ak_keyer_test.sv
/*
 Self-checking bench for the keying sequencer, with shortened counts.
 Assumes the package, the buffer and the transmitter model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module ak_keyer_test;
	import ak_pkg::*;
	localparam int S = 20;
	localparam int B = 8;
	logic        clk_in        = 1'b0;
	logic        nrst_in       = 1'b0;
	logic        start_in      = 1'b0;
	ak_mode_type mode_in       = AK_MODE_ASK;
	logic [7:0]  batt_level_in = 8'h80;
	logic [7:0]  batt_min_in   = 8'h40;
	logic        bit_valid_in  = 1'b0;
	logic        bit_data_in   = 1'b0;
	logic        bit_last_in   = 1'b0;
	logic        rdy, busy, done, unr, lowb, pd, amp, freq;
	logic        pwr, osc, pa, fhi;
	int          errors          = 0;
	int          samples_checked = 0;
	always #2 clk_in = ~clk_in;
	ak_keyer #(.STARTUP_CYC(S), .BIT_CYC(B)) u_ak_keyer (.clk_in(clk_in), .nrst_in(nrst_in),
		.start_in(start_in), .mode_in(mode_in), .batt_level_in(batt_level_in),
		.batt_min_in(batt_min_in), .bit_valid_in(bit_valid_in), .bit_data_in(bit_data_in),
		.bit_last_in(bit_last_in), .bit_ready_out(rdy), .busy_out(busy), .done_out(done),
		.underrun_out(unr), .low_batt_out(lowb), .power_down_line_out(pd),
		.amp_key_line_out(amp), .freq_key_line_out(freq));
	ak_tx_model u_ak_tx_model (.power_down_line_in(pd), .amp_key_line_in(amp),
		.freq_key_line_in(freq), .mode_in(mode_in), .powered_out(pwr), .osc_on_out(osc),
		.pa_on_out(pa), .freq_hi_out(fhi));
	task automatic tally_and_finish;
		if (errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string name, input logic [2:0] seen, input logic [2:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic push(input logic d, input logic l);
		@(posedge clk_in);
		bit_valid_in <= 1'b1;
		bit_data_in  <= d;
		bit_last_in  <= l;
		repeat (200) begin
			@(posedge clk_in);
			if (rdy === 1'b1)
				break;
		end
		bit_valid_in <= 1'b0;
	endtask
	task automatic kick;
		@(posedge clk_in);
		start_in <= 1'b1;
		@(posedge clk_in);
		start_in <= 1'b0;
	endtask
	task automatic frame(input ak_mode_type m, input logic [2:0] bits);
		logic ask;
		ask = (m == AK_MODE_ASK);
		@(posedge clk_in);
		mode_in <= m;
		push(bits[0], 1'b0);
		push(bits[1], 1'b0);
		#1;
		chk("ready_full", {2'h0, rdy}, 3'h0);
		fork
			push(bits[2], 1'b1);
			begin
				kick;
				// warm-up pins stand from the edge that takes start, for S cycles
				for (int i = 0; i < S; i++) begin
					#1;
					chk("warm_pins", {pd, amp, freq}, 3'h5);
					chk("warm_model", {busy, osc, pa}, 3'h6);
					@(posedge clk_in);
				end
				for (int k = 0; k < 3; k++) begin
					for (int i = 0; i < B; i++) begin
						#1;
						chk("cell_pins", {pd, amp, freq}, {1'b1, ask ? bits[k] : 1'b1,
							ask ? 1'b1 : bits[k]});
						chk("cell_model", {osc, pa, fhi}, {1'b1, ask ? bits[k] : 1'b1,
							ask ? 1'b0 : bits[k]});
						@(posedge clk_in);
					end
				end
				#1;
				chk("end_pins", {pd, amp, freq}, 3'h0);
				chk("end_flags", {busy, done, unr}, 3'h2);
				chk("end_model", {pwr, osc, pa}, 3'h0);
			end
		join
	endtask
	task automatic low_battery;
		@(posedge clk_in);
		batt_level_in <= 8'h3F;
		kick;
		#1;
		chk("low_batt", {lowb, busy, pd}, 3'h4);
		@(posedge clk_in);
		batt_level_in <= 8'h80;
	endtask
	task automatic starve;
		push(1'b1, 1'b0);
		kick;
		repeat (S + B) @(posedge clk_in);
		#1;
		chk("starve_pins", {pd, amp, freq}, 3'h0);
		chk("starve_flags", {busy, done, unr}, 3'h1);
	endtask
	// warm-up must stretch past S while nothing is queued, then key a single last bit
	task automatic stretch;
		kick;
		repeat (S + 4) @(posedge clk_in);
		#1;
		chk("stretch_pins", {pd, amp, freq}, 3'h5);
		push(1'b1, 1'b1);
		#1;
		chk("stretch_hold", {pd, amp, freq}, 3'h5);
		@(posedge clk_in);
		#1;
		chk("stretch_key", {pd, amp, freq}, 3'h7);
		repeat (B) @(posedge clk_in);
		#1;
		chk("stretch_end", {busy, done, pd}, 3'h2);
	endtask
	// reset in mid-frame must drop the pins and busy at once and leave the buffer ready
	task automatic mid_reset;
		push(1'b0, 1'b0);
		kick;
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b0;
		#1;
		chk("rst_pins", {pd, amp, freq}, 3'h0);
		chk("rst_flags", {busy, rdy, pwr}, 3'h2);
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		#1;
		chk("rst_after", {busy, rdy, pwr}, 3'h2);
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		#1;
		chk("reset_pins", {pd, amp, freq}, 3'h0);
		chk("reset_model", {pwr, osc, pa}, 3'h0);
		frame(AK_MODE_ASK, 3'h5);
		frame(AK_MODE_FSK, 3'h2);
		low_battery;
		starve;
		stretch;
		mid_reset;
		tally_and_finish;
	end
	// the whole sequence needs a few hundred cycles; this leaves ample margin
	initial begin
		#50000;
		errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ### bench/ak_tx_model.sv
/*
 Behavioural transmitter that sits on the far side of the keying pins.
 Assumes push-pull pins from the sequencer; the mode is fixed by board assembly.
*/
`timescale 1ns/1ps
`default_nettype none
module ak_tx_model (
	input  wire logic                power_down_line_in,
	input  wire logic                amp_key_line_in,
	input  wire logic                freq_key_line_in,
	input  wire ak_pkg::ak_mode_type mode_in,
	output logic                     powered_out,
	output logic                     osc_on_out,
	output logic                     pa_on_out,
	output logic                     freq_hi_out
);
	import ak_pkg::*;
	// wired or: a stray high on any one line wakes the chip
	assign powered_out = power_down_line_in | amp_key_line_in | freq_key_line_in;
	// oscillator and synthesizer follow power, never the amplitude key
	assign osc_on_out  = powered_out;
	assign pa_on_out   = powered_out & amp_key_line_in;
	assign freq_hi_out = (mode_in == AK_MODE_FSK) ? freq_key_line_in : 1'b0;
endmodule
`default_nettype wire

// ### common/ak_bit_if.sv
/*
 Valid/ready carrier for coded bits between the sequencer and its buffer.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface ak_bit_if #(parameter int W = 2);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### common/ak_params.svh
/*
 Timing constants and buffer shape for the ASK/FSK keying sequencer.
 Assumes a 250 MHz core clock; cycle counts derive from the times below.
*/
// Summary of operation
// - finish reference oscillator warm-up before keying any data bit
// - ask mode: frequency key held high, amplitude key follows the bit stream
// - fsk warm-up: frequency key high, amplitude key low until lock
// - fsk keying: frequency key follows the bit stream, amplitude key high
// - battery level may be checked with an 8 bit converter before sending
// - each frame starts with synthesizer enabled about 1..3 ms, amplifier off
// - when idle drive power-down, amplitude and frequency key lines all low
`ifndef AK_PARAMS_SVH
`define AK_PARAMS_SVH
`define AK_CLK_MHZ     250
`define AK_STARTUP_US  2000
`define AK_STARTUP_CYC (`AK_STARTUP_US * `AK_CLK_MHZ)
`define AK_BIT_US      500
`define AK_BIT_CYC     (`AK_BIT_US * `AK_CLK_MHZ)
`define AK_ADC_W       8
`define AK_BUF_DEPTH   2
`define AK_BUF_W       2
`endif

// ### common/ak_pkg.sv
/*
 Types shared by the keying sequencer and the transmitter model.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ak_pkg;
	typedef enum logic [1:0] {
		AK_IDLE = 2'h0,
		AK_WARM = 2'h1,
		AK_KEY  = 2'h2
	} ak_state_type;
	typedef enum logic {
		AK_MODE_ASK = 1'h0,
		AK_MODE_FSK = 1'h1
	} ak_mode_type;
endpackage

// ### core/ak_buf2.sv
/*
 Small FIFO for coded bits; entries are registers, read data is muxed from them without a register.
 Assumes DEPTH is a power of two so pointers wrap by overflow.
*/
`timescale 1ns/1ps
`default_nettype none
module ak_buf2 #(
	parameter int W     = 2,
	parameter int DEPTH = 2
) (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	ak_bit_if.snk     in_if,
	ak_bit_if.src     out_if
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	wire           push = in_if.valid & in_if.ready;
	wire           pop  = out_if.valid & out_if.ready;

	assign in_if.ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_if.valid = (cnt_q != '0);
	assign out_if.data  = mem_q[rp_q];

	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		always_ff @(posedge clk_in or negedge nrst_in) begin
			if (!nrst_in)
				mem_q[g] <= '0;
			else if (push && wp_q == AW'(g))
				mem_q[g] <= in_if.data;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ### core/ak_keyer.sv
/*
 Host-side keying sequencer for a 433 MHz ASK/FSK transmitter.
 Drives the power-down, amplitude-key and frequency-key pins; takes coded
 bits from user logic on the same clock through a two-entry buffer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ak_params.svh"
module ak_keyer #(
	parameter int STARTUP_CYC = `AK_STARTUP_CYC,
	parameter int BIT_CYC     = `AK_BIT_CYC
) (
	input  wire logic                 clk_in,
	input  wire logic                 nrst_in,
	input  wire logic                 start_in,
	input  wire ak_pkg::ak_mode_type  mode_in,
	input  wire logic [`AK_ADC_W-1:0] batt_level_in,
	input  wire logic [`AK_ADC_W-1:0] batt_min_in,
	input  wire logic                 bit_valid_in,
	input  wire logic                 bit_data_in,
	input  wire logic                 bit_last_in,
	output logic                      bit_ready_out,
	output logic                      busy_out,
	output logic                      done_out,
	output logic                      underrun_out,
	output logic                      low_batt_out,
	output logic                      power_down_line_out,
	output logic                      amp_key_line_out,
	output logic                      freq_key_line_out
);
	import ak_pkg::*;

	// pin levels as {power_down, amp_key, freq_key}
	function automatic logic [2:0] lines_for(ak_state_type st, ak_mode_type md, logic b);
		logic [2:0] l;
		l = 3'h0;
		case (st)
			AK_WARM: l = 3'h5;
			AK_KEY:  l = (md == AK_MODE_ASK) ? {1'b1, b, 1'b1} : {1'b1, 1'b1, b};
			default: l = 3'h0;
		endcase
		return l;
	endfunction

	ak_bit_if #(.W(`AK_BUF_W)) up_if ();
	ak_bit_if #(.W(`AK_BUF_W)) dn_if ();

	ak_buf2 #(
		.W     (`AK_BUF_W),
		.DEPTH (`AK_BUF_DEPTH)
	) u_buf (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.in_if   (up_if),
		.out_if  (dn_if)
	);

	ak_state_type state_q;
	ak_state_type state_d;
	ak_mode_type  mode_q;
	logic [31:0]  cnt_q;
	logic [31:0]  cnt_d;
	logic         bit_q;
	logic         bit_d;
	logic         last_q;
	logic [2:0]   lines_q;
	logic         done_q;
	logic         under_q;
	logic         lowb_q;

	wire batt_low   = (batt_level_in < batt_min_in);
	wire start_ok   = (state_q == AK_IDLE) && start_in && !batt_low;
	wire start_bad  = (state_q == AK_IDLE) && start_in && batt_low;
	wire warm_end   = (state_q == AK_WARM) && (cnt_q == 32'(STARTUP_CYC - 1));
	wire cell_end   = (state_q == AK_KEY) && (cnt_q == 32'(BIT_CYC - 1));
	// warm-up simply stretches while no bit is queued, never keys early
	wire take       = dn_if.valid && (warm_end || (cell_end && !last_q));
	wire frame_done = cell_end && last_q;
	wire starve     = cell_end && !last_q && !dn_if.valid;
	wire [2:0] lines_d = lines_for(state_d, (state_q == AK_IDLE) ? mode_in : mode_q, bit_d);

	assign up_if.valid = bit_valid_in;
	assign up_if.data  = {bit_last_in, bit_data_in};
	assign dn_if.ready = take;
	assign bit_ready_out = up_if.ready;

	assign state_d = start_ok               ? AK_WARM :
	                 take                   ? AK_KEY  :
	                 (frame_done || starve) ? AK_IDLE : state_q;
	assign cnt_d   = (start_ok || take) ? 32'h0 :
	                 (state_d != state_q) ? 32'h0 :
	                 (state_q == AK_WARM && cnt_q == 32'(STARTUP_CYC - 1)) ? cnt_q :
	                 cnt_q + 32'h1;
	assign bit_d   = take ? dn_if.data[0] : (state_d == AK_KEY) ? bit_q : 1'b0;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= AK_IDLE;
			cnt_q   <= 32'h0;
			bit_q   <= 1'b0;
			last_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			bit_q   <= bit_d;
			last_q  <= take ? dn_if.data[1] : last_q;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			mode_q <= AK_MODE_ASK;
		else if (start_ok)
			mode_q <= mode_in;
	end

	// pins come from flops so no decode glitch reaches the transmitter inputs
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			lines_q <= 3'h0;
		else
			lines_q <= lines_d;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			done_q  <= 1'b0;
			under_q <= 1'b0;
			lowb_q  <= 1'b0;
		end else begin
			done_q  <= frame_done;
			under_q <= starve;
			lowb_q  <= start_bad;
		end
	end

	// power-down pin held high the whole frame so the synthesizer never drops
	assign power_down_line_out = lines_q[2];
	assign amp_key_line_out    = lines_q[1];
	assign freq_key_line_out   = lines_q[0];
	assign busy_out            = (state_q != AK_IDLE);
	assign done_out            = done_q;
	assign underrun_out        = under_q;
	assign low_batt_out        = lowb_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_idle_lines_low: assert property (
		(state_q == AK_IDLE && $past(state_q) == AK_IDLE) |->
		(lines_q == 3'h0))
		else $error("pins not all low while idle");
	a_warm_amp_off: assert property (
		(state_q == AK_WARM) |=> (freq_key_line_out && !amp_key_line_out
		&& power_down_line_out) || state_q != AK_WARM)
		else $error("warm-up pins wrong");
	a_warm_full_length: assert property (
		(state_q == AK_KEY && $past(state_q) == AK_WARM) |->
		($past(cnt_q) == 32'(STARTUP_CYC - 1)))
		else $error("keying began before warm-up ended");
	// pins are registered from the next state, so they line up with state_q and bit_q
	a_ask_freq_high: assert property (
		(state_q == AK_KEY && mode_q == AK_MODE_ASK) |->
		(freq_key_line_out && amp_key_line_out == bit_q))
		else $error("ask keying pins wrong");
	a_fsk_amp_high: assert property (
		(state_q == AK_KEY && mode_q == AK_MODE_FSK) |->
		(amp_key_line_out && freq_key_line_out == bit_q))
		else $error("fsk keying pins wrong");
	a_bit_cell_fixed: assert property (
		(dn_if.ready && state_q == AK_KEY) |->
		(cnt_q == 32'(BIT_CYC - 1)))
		else $error("bit taken off a cell boundary");
	a_low_batt_refuse: assert property (
		start_bad |=> (low_batt_out && state_q == AK_IDLE))
		else $error("frame started on low battery");
	a_frame_power_held: assert property (
		(state_q != AK_IDLE && $past(state_q) != AK_IDLE) |->
		power_down_line_out && (amp_key_line_out || freq_key_line_out ||
		mode_q == AK_MODE_FSK))
		else $error("transmitter power dropped inside frame");
	a_frame_end_idle: assert property (
		frame_done |=> (lines_q == 3'h0 && done_out))
		else $error("pins not released after frame");

	c_ask_frame: cover property (done_out && mode_q == AK_MODE_ASK);
	c_fsk_frame: cover property (done_out && mode_q == AK_MODE_FSK);
	c_underrun:  cover property (underrun_out);
	c_buf_full:  cover property (bit_valid_in && !bit_ready_out);
endmodule
`default_nettype wire
